// *** verilog/vir_params.svh ***
// Purpose: Constants for the two-source vectored interrupt requester.
// Assumes: 10 MHz system clock.
// Notes:   Definitions only.
`ifndef VIR_PARAMS_SVH
`define VIR_PARAMS_SVH

// ==========================================================
// Register map (byte addresses)
`define RX_STATUS_OFS 8'h00
`define TX_STATUS_OFS 8'h04

// ==========================================================
// Field positions
`define RX_MC_BIT 15
`define RX_DONE_BIT 7
`define RX_IE_BIT 6
`define RX_MCIE_BIT 5
`define TX_DONE_BIT 7
`define TX_IE_BIT 6

// ==========================================================
// Reset values
`define FLAG_RST 1'b0
`define STATE_RST 3'h0

// ==========================================================
// Timing
`define CLK_PERIOD_NS 100
`define GRANT_DELAY_NS 50
`define RX_REQ_DELAY_NS 100
`define RING_QUAL_MS 10
`define GRANT_DELAY_CYC \
    ((`GRANT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RX_REQ_DELAY_CYC \
    ((`RX_REQ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RING_QUAL_CYC \
    ((`RING_QUAL_MS * 1000000) / `CLK_PERIOD_NS + 1)

// ==========================================================
// Widths
`define VEC_W 7
`define SW_W 6
`define LVL_N 4
`define CNT_W 4
`define RING_CNT_W 20

`endif

// *** verilog/vir_pkg.sv ***
// Purpose: Types for the two-source vectored interrupt requester.
// Assumes: Constants come from vir_params.svh.
// Notes:   States, bus line bundles.
package vir_pkg;

    // ==========================================================
    // Handshake states
    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_GRANT  = 3'b001,
        ST_SACK   = 3'b010,
        ST_MASTER = 3'b011,
        ST_DONE   = 3'b100
    } state_t;

    // ==========================================================
    // Shared bus lines as read back (low = asserted)
    typedef struct packed
    {
        logic bbsy_n;
        logic ssyn_n;
    } bus_in_t;

    // Open-drain enables (high = pulling the line low)
    typedef struct packed
    {
        logic [3:0] br;
        logic bbsy;
        logic sack;
        logic intr;
        logic [6:0] db;
    } od_t;

endpackage : vir_pkg

// *** verilog/sync2.sv ***
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are slow static or handshake levels.
// Notes:   Only the second stage is visible.
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta_q;

    // ==========================================================
    // Two stages
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_q <= '0;
            o_q <= '0;
        end
        else if (i_ce)
        begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end

endmodule : sync2

// *** verilog/ring_qualifier.sv ***
// Purpose: Pulse when the ring line has stayed high past a minimum time.
// Assumes: Input already synchronised.
// Notes:   One pulse per qualified ring; counter saturates.
`timescale 1ns/1ps
`include "vir_params.svh"
module ring_qualifier #(
    parameter int unsigned QUAL_CYC = `RING_QUAL_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Ring level and qualified event
    input wire logic i_ring,
    output logic o_ring_event
);

    logic [`RING_CNT_W-1:0] cnt_q;
    wire logic [`RING_CNT_W-1:0] limit = QUAL_CYC[`RING_CNT_W-1:0];
    wire logic hit = (cnt_q == limit);

    // ==========================================================
    // Count high time, fire once on reaching the limit
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= '0;
            o_ring_event <= 1'b0;
        end
        else if (i_ce)
        begin
            if (!i_ring)
                cnt_q <= '0;
            else if (!hit)
                cnt_q <= cnt_q + 1'b1;
            o_ring_event <= i_ring && (cnt_q == limit - 1'b1);
        end
    end

endmodule : ring_qualifier

// *** verilog/vir_top.sv ***
// Purpose: Two-source vectored interrupt requester with status registers.
// Assumes: Classic Wishbone slave; shared bus lines are open drain.
// Notes:   No DMA path; one request level chosen by a static input.
// Function
// - Vector bits 8..3 from six settings, bit 2 by logic, bits 1,0 zero.
// - Setting on drives the vector bit as one; off leaves it undriven.
// - Data lines are inverted: low is logical one.
// - Receiver service gives vector ending 0, transmitter ending 4.
// - Both sources share one request level.
// - Receiver wins when both sources request together.
// - Only the chosen level is requested; other grants pass through.
// - Chosen-level grant forwarded when idle, absorbed when requesting.
// - Only slave register transfers and interrupts; never DMA.
// - Transmit request is done flag AND transmit enable.
// - Transmit done sets when the transmit buffer frees.
// - Receive request: done AND enable, or modem change AND enable.
// - Receive request held off while receive status is read.
// - Receive request reaches its capture flop after about 100 ns.
// - Receive done sets on character load while receiver active.
// - Modem change sets on any CTS edge or ring high over 10 ms.
// - Vector drivers enabled only once bus busy is owned.
// - After grant wait two cycles (200 ns, over 50 ns), assert SACK, drop request.
// - On bus free: take busy, drop SACK, latch bit 2, interrupt.
// - On slave sync: release bus, lock the serviced request flop.
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "vir_params.svh"
module vir_top
    import vir_pkg::*;
#(
    parameter int unsigned RING_QUAL_CYC = `RING_QUAL_CYC
) (
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Serial datapath events (same clock)
    input wire logic i_rx_active,
    input wire logic i_rx_char_load,
    input wire logic i_rx_buf_read,
    input wire logic i_tx_buf_free,
    input wire logic i_tx_buf_load,
    // Modem pins
    input wire logic i_cts,
    input wire logic i_ring,
    // Static settings
    input wire logic [`SW_W-1:0] i_vector_sw,
    input wire logic [1:0] i_level_sel,
    // Shared interrupt bus
    input wire logic [`LVL_N-1:0] i_grant_chain_in,
    output logic [`LVL_N-1:0] o_grant_chain_out,
    input wire bus_in_t i_bus_in,
    input wire od_t i_od_in,
    output od_t o_od_o,
    output od_t o_od_oe
);

    // ==========================================================
    // Pin synchronisers
    logic [`LVL_N-1:0] grant_s;
    logic [`SW_W-1:0] sw_s;
    logic [1:0] lvl_s;
    logic bbsy_n_s;
    logic ssyn_n_s;
    logic cts_s;
    logic ring_s;
    logic ring_event;

    sync2 #(.W(`LVL_N + `SW_W + 6)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_d({i_grant_chain_in, i_vector_sw, i_level_sel,
              i_bus_in.bbsy_n, i_bus_in.ssyn_n, i_cts, i_ring}),
        .o_q({grant_s, sw_s, lvl_s, bbsy_n_s, ssyn_n_s, cts_s, ring_s})
    );

    ring_qualifier #(.QUAL_CYC(RING_QUAL_CYC)) u_ring (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_ring(ring_s),
        .o_ring_event(ring_event)
    );

    // ==========================================================
    // Register state
    logic rx_done_flag_q;
    logic rx_int_enable_q;
    logic modem_change_int_enable_q;
    logic modem_change_flag_q;
    logic tx_done_flag_q;
    logic tx_int_enable_q;
    logic cts_d1_q;
    logic o_ack_q;
    logic [31:0] rdata_q;

    // ==========================================================
    // Bus decode
    function automatic logic hit_ofs(input logic [7:0] a,
                                     input logic [7:0] ofs);
        hit_ofs = (a == ofs);
    endfunction : hit_ofs

    wire logic wb_req = i_wb_cyc && i_wb_stb && !o_ack_q;
    wire logic sel_rx = hit_ofs(i_wb_adr, `RX_STATUS_OFS);
    wire logic sel_tx = hit_ofs(i_wb_adr, `TX_STATUS_OFS);
    wire logic wr_rx = wb_req && i_wb_we && sel_rx;
    wire logic wr_tx = wb_req && i_wb_we && sel_tx;
    wire logic rx_status_read_strobe = wb_req && !i_wb_we && sel_rx;
    wire logic lane0 = i_wb_sel[0];
    wire logic lane1 = i_wb_sel[1];

    // Read data views
    wire logic [31:0] rx_view = {16'h0000, modem_change_flag_q, 7'h00,
        rx_done_flag_q, rx_int_enable_q, modem_change_int_enable_q,
        5'h00};
    wire logic [31:0] tx_view = {24'h000000, tx_done_flag_q,
        tx_int_enable_q, 6'h00};
    wire logic [31:0] rdata_d = sel_rx ? rx_view :
                                sel_tx ? tx_view : 32'h00000000;

    // Flag events; a set in the clearing cycle wins
    wire logic cts_edge = cts_s ^ cts_d1_q;
    wire logic mc_set = cts_edge || ring_event;
    wire logic mc_clr = wr_rx && lane1 && i_wb_dat[`RX_MC_BIT];
    wire logic rx_set = i_rx_active && i_rx_char_load;

    // ==========================================================
    // Wishbone answer: one cycle after the request
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else if (i_ce)
        begin
            o_ack_q <= wb_req;
            rdata_q <= wb_req ? rdata_d : 32'h00000000;
        end
    end

    assign o_wb_ack = o_ack_q;
    assign o_wb_dat = rdata_q;

    // ==========================================================
    // Status and enable bits
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_done_flag_q <= `FLAG_RST;
            rx_int_enable_q <= `FLAG_RST;
            modem_change_int_enable_q <= `FLAG_RST;
            modem_change_flag_q <= `FLAG_RST;
            tx_done_flag_q <= `FLAG_RST;
            tx_int_enable_q <= `FLAG_RST;
            cts_d1_q <= 1'b0;
        end
        else if (i_ce)
        begin
            cts_d1_q <= cts_s;
            if (wr_rx && lane0)
            begin
                rx_int_enable_q <= i_wb_dat[`RX_IE_BIT];
                modem_change_int_enable_q <= i_wb_dat[`RX_MCIE_BIT];
            end
            if (wr_tx && lane0)
                tx_int_enable_q <= i_wb_dat[`TX_IE_BIT];
            if (rx_set)
                rx_done_flag_q <= 1'b1;
            else if (i_rx_buf_read)
                rx_done_flag_q <= 1'b0;
            if (mc_set)
                modem_change_flag_q <= 1'b1;
            else if (mc_clr)
                modem_change_flag_q <= 1'b0;
            if (i_tx_buf_free)
                tx_done_flag_q <= 1'b1;
            else if (i_tx_buf_load)
                tx_done_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // Source requests
    wire logic tx_req = tx_done_flag_q && tx_int_enable_q;
    wire logic rx_req_raw = ((rx_done_flag_q && rx_int_enable_q) ||
        (modem_change_flag_q && modem_change_int_enable_q))
        && !rx_status_read_strobe;
    logic [`CNT_W-1:0] rx_dly_q;
    wire logic rx_req = rx_dly_q[`RX_REQ_DELAY_CYC-1];
    // Delay line for the receive request
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            rx_dly_q <= '0;
        else if (i_ce)
            rx_dly_q <= {rx_dly_q[`CNT_W-2:0], rx_req_raw};
    end

    // ==========================================================
    // Request capture and hold-set locks
    state_t state_q;
    logic req_a_q;
    logic req_b_q;
    logic vector_bit2_latch_q;
    logic [`CNT_W-1:0] gcnt_q;
    wire logic rx_pend = rx_req && !req_a_q;
    wire logic tx_pend = tx_req && !req_b_q;
    wire logic requesting = rx_pend || tx_pend;
    wire logic lock = (state_q == ST_MASTER) && !ssyn_n_s;
    wire logic grant_mine = grant_s[lvl_s];
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            req_a_q <= `FLAG_RST;
            req_b_q <= `FLAG_RST;
        end
        else if (i_ce)
        begin
            if (lock && vector_bit2_latch_q)
                req_a_q <= 1'b1;
            else if (!rx_req)
                req_a_q <= 1'b0;
            if (lock && !vector_bit2_latch_q)
                req_b_q <= 1'b1;
            else if (!tx_req)
                req_b_q <= 1'b0;
        end
    end

    // ==========================================================
    // Bus handshake sequencer
    state_t state_d;
    wire logic gdone = (gcnt_q == `CNT_W'(`GRANT_DELAY_CYC));
    wire logic bus_free = bbsy_n_s && ssyn_n_s && !grant_mine;
    // Bit 2 choice, fresh on the edge the bus is won
    wire logic bit2_sel_d = (state_q == ST_SACK && bus_free) ? rx_pend :
        vector_bit2_latch_q;
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (requesting && grant_mine)
                    state_d = ST_GRANT;
            ST_GRANT:
                if (gdone)
                    state_d = ST_SACK;
            ST_SACK:
                if (bus_free)
                    state_d = ST_MASTER;
            ST_MASTER:
                if (!ssyn_n_s)
                    state_d = ST_DONE;
            ST_DONE:
                if (ssyn_n_s)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= state_t'(`STATE_RST);
            gcnt_q <= '0;
            vector_bit2_latch_q <= 1'b0;
        end
        else if (i_ce)
        begin
            state_q <= state_d;
            gcnt_q <= (state_q == ST_GRANT) ? gcnt_q + 1'b1 : '0;
            vector_bit2_latch_q <= bit2_sel_d;
        end
    end

    // ==========================================================
    // Line drive: no DMA line exists, only BR, SACK, BBSY, INTR, data
    od_t oe_d;
    wire logic master = (state_d == ST_MASTER);
    wire logic br_on = requesting &&
        (state_d == ST_IDLE || state_d == ST_GRANT);
    always_comb
    begin
        oe_d = '0;
        oe_d.br[lvl_s] = br_on;
        oe_d.sack = (state_d == ST_SACK);
        oe_d.bbsy = master;
        oe_d.intr = master;
        // Vector bits 8..3 pulled low where the setting is on
        oe_d.db[6:1] = master ? sw_s : '0;
        // Bit 2 pulled low (logical one) only for transmitter
        oe_d.db[0] = master && !bit2_sel_d;
    end

    // Grant chain: others pass, mine only when not requesting
    logic [`LVL_N-1:0] gout_d;
    always_comb
    begin
        gout_d = grant_s;
        gout_d[lvl_s] = grant_mine && !requesting &&
            (state_q == ST_IDLE);
    end
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_od_oe <= '0;
            o_od_o <= '0;
            o_grant_chain_out <= '0;
        end
        else if (i_ce)
        begin
            o_od_oe <= oe_d;
            o_od_o <= '0;
            o_grant_chain_out <= gout_d;
        end
    end

endmodule : vir_top

// *** verif/vir_props.sv ***
// Purpose: Port checks for the vectored interrupt requester.
// Assumes: Settings change only while the requester is idle.
// Notes:   Bounds allow for the two-flop input sync.
`timescale 1ns/1ps
module vir_props
    import vir_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Watched ports
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [5:0] i_vector_sw,
    input wire logic [1:0] i_level_sel,
    input wire bus_in_t i_bus_in,
    input wire logic [3:0] o_grant_chain_out,
    input wire od_t o_od_o,
    input wire od_t o_od_oe
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // ========================================
    // Interrupt bus handshake and vector
    lvl_only_a: assert property (o_od_oe.br == 4'h0 ||
        o_od_oe.br == (4'h1 << i_level_sel)) else $error("br level");
    vec_gate_a: assert property ((|o_od_oe.db) |->
        o_od_oe.bbsy) else $error("vector without busy");
    vec_sw_a: assert property (o_od_oe.bbsy |->
        o_od_oe.db[6:1] == i_vector_sw) else $error("vector bits");
    drive_low_a: assert property (o_od_o == '0)
        else $error("line driven high");
    sack_drop_a: assert property ($rose(o_od_oe.sack) |->
        o_od_oe.br == 4'h0) else $error("request kept at sack");
    take_bus_a: assert property ($rose(o_od_oe.bbsy) |->
        o_od_oe.intr && !o_od_oe.sack && $past(o_od_oe.sack))
        else $error("bus taken out of order");
    absorb_a: assert property (o_od_oe.sack |->
        !o_grant_chain_out[i_level_sel]) else $error("grant passed");
    release_a: assert property (o_od_oe.intr && !i_bus_in.ssyn_n
        |-> ##[1:5] !o_od_oe.intr && !o_od_oe.bbsy) else $error("no release");
    // Register port
    wb_ack_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack ##1 !o_wb_ack) else $error("ack timing");
    unmapped_a: assert property (o_wb_ack && !i_wb_we &&
        i_wb_adr != 8'h00 && i_wb_adr != 8'h04 |-> o_wb_dat == 32'h0)
        else $error("unmapped read");
    // Main scenarios
    cover property ($rose(o_od_oe.bbsy) && o_od_oe.db[0]);
    cover property ($rose(o_od_oe.bbsy) && !o_od_oe.db[0]);
    cover property ($rose(o_grant_chain_out[i_level_sel]));
endmodule : vir_props

bind vir_top vir_props props_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_vector_sw(i_vector_sw), .i_level_sel(i_level_sel),
    .i_bus_in(i_bus_in), .o_grant_chain_out(o_grant_chain_out),
    .o_od_o(o_od_o), .o_od_oe(o_od_oe));

// *** verif/bus_master_model.sv ***
// Purpose: Processor and arbiter at the far side of the interrupt bus.
// Assumes: Lines are pulled up; a set enable pulls a line low.
// Notes:   i_wait_cyc slows both grant and slave sync answers.
`timescale 1ns/1ps
module bus_master_model
    import vir_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Settings
    input wire logic [1:0] i_level_sel,
    input wire logic [3:0] i_wait_cyc,
    // Device lines
    input wire od_t i_od_oe,
    output logic [3:0] o_grant,
    output bus_in_t o_bus,
    output logic [6:0] o_vec,
    output logic o_vec_stb
);
    logic [3:0] cnt_q;
    logic ssyn_n_q;
    // Pulled-up busy line, low only while the device pulls it
    assign o_bus = {~i_od_oe.bbsy, ssyn_n_q};
    // Grant after a wait, then slave sync once the vector is up
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_grant <= 4'h0;
            ssyn_n_q <= 1'b1;
            cnt_q <= 4'h0;
            o_vec <= 7'h0;
            o_vec_stb <= 1'b0;
        end
        else
        begin
            o_vec_stb <= 1'b0;
            if (i_od_oe.intr)
            begin
                if (ssyn_n_q && cnt_q == i_wait_cyc)
                begin
                    ssyn_n_q <= 1'b0;
                    o_vec <= i_od_oe.db;
                    o_vec_stb <= 1'b1;
                end
                else if (ssyn_n_q)
                    cnt_q <= cnt_q + 4'h1;
            end
            else if (i_od_oe.sack)
            begin
                o_grant <= 4'h0;
                cnt_q <= 4'h0;
            end
            else if (i_od_oe.br[i_level_sel])
            begin
                if (cnt_q == i_wait_cyc)
                    o_grant[i_level_sel] <= 1'b1;
                else
                    cnt_q <= cnt_q + 4'h1;
            end
            else
            begin
                ssyn_n_q <= 1'b1;
                cnt_q <= 4'h0;
            end
        end
    end
endmodule : bus_master_model

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the vectored interrupt requester.
// Assumes: Register port is classic Wishbone; ring time shortened to 20.
// Notes:   Events are single-cycle pulses on the system clock.
`timescale 1ns/1ps
module tb
    import vir_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic rx_active = 1'b0;
    logic [3:0] ev = 4'h0;
    logic cts = 1'b0;
    logic ring = 1'b0;
    logic [5:0] vector_sw = 6'h0;
    logic [1:0] level_sel = 2'h0;
    logic [3:0] wait_cyc = 4'h0;
    logic [3:0] extra_grant = 4'h0;
    logic [3:0] arb_grant;
    logic [3:0] grant_out;
    logic [6:0] vec;
    logic vec_stb;
    bus_in_t bus_in;
    od_t od_o;
    od_t od_oe;
    int n_errors = 0;
    int checks_done = 0;
    // ========================================
    // Clock, design and far side
    always #50 clk = ~clk;
    vir_top #(.RING_QUAL_CYC(20)) dut_u (.i_sys_clk(clk), .i_rst(rst),
        .i_ce(1'b1), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
        .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat_w),
        .o_wb_dat(wb_dat_r), .o_wb_ack(wb_ack), .i_rx_active(rx_active),
        .i_rx_char_load(ev[3]), .i_rx_buf_read(ev[2]),
        .i_tx_buf_free(ev[1]), .i_tx_buf_load(ev[0]), .i_cts(cts),
        .i_ring(ring), .i_vector_sw(vector_sw), .i_level_sel(level_sel),
        .i_grant_chain_in(arb_grant | extra_grant),
        .o_grant_chain_out(grant_out), .i_bus_in(bus_in), .i_od_in('0),
        .o_od_o(od_o), .o_od_oe(od_oe));
    bus_master_model far_u (.i_sys_clk(clk), .i_rst(rst),
        .i_level_sel(level_sel), .i_wait_cyc(wait_cyc), .i_od_oe(od_oe),
        .o_grant(arb_grant), .o_bus(bus_in), .o_vec(vec),
        .o_vec_stb(vec_stb));
    // ========================================
    // Closing report and comparison
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr,
        input logic [31:0] d, input logic [3:0] sel, output logic [31:0] q);
        int n;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat_w <= d;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (wb_ack === 1'b1)
                break;
        end
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n == 20)
        begin
            chk("wishbone ack", 32'h1, 32'h0);
            end_of_test();
        end
    endtask : wb
    task automatic wr(input logic [7:0] adr, input logic [31:0] d,
        input logic [3:0] sel);
        logic [31:0] q;
        wb(1'b1, adr, d, sel, q);
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] adr,
        input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, adr, 32'h0, 4'hf, q);
        chk(what, exp, q);
    endtask : rd_chk
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 4'h0;
    endtask : pulse
    // Wait for the vector read by the far side
    task automatic wait_vec(input logic [6:0] exp);
        int n;
        for (n = 0; n < 300 && vec_stb !== 1'b1; n++)
            @(posedge clk);
        if (n == 300)
        begin
            chk("vector wait", 32'h1, 32'h0);
            end_of_test();
        end
        chk("vector", {25'h0, exp}, {25'h0, vec});
        idle(8);
    endtask : wait_vec
    task automatic no_vec(input int n);
        int seen;
        seen = 0;
        repeat (n)
        begin
            @(posedge clk);
            seen += int'(vec_stb === 1'b1);
        end
        chk("vectors while locked", 32'h0, 32'(seen));
    endtask : no_vec
    // ========================================
    // Main sequence
    initial
    begin
        idle(4);
        rst <= 1'b0;
        rd_chk("rx status", 8'h00, 32'h0);
        rd_chk("tx status", 8'h04, 32'h0);
        wr(8'h08, 32'hffffffff, 4'hf);
        rd_chk("unmapped", 8'h08, 32'h0);
        extra_grant <= 4'hf;
        idle(8);
        chk("grant pass", 32'hf, {28'h0, grant_out});
        extra_grant <= 4'h0;
        idle(8);
        chk("grant off", 32'h0, {28'h0, grant_out});
        // Transmitter vector on every level, prompt and slow far side
        for (int l = 0; l < 4; l++)
        begin
            level_sel <= 2'(l);
            vector_sw <= {2'(l), 4'ha};
            wait_cyc <= 4'(l * 4);
            idle(6);
            wr(8'h04, 32'h40, 4'h1);
            pulse(4'b0010);
            rd_chk("tx done", 8'h04, 32'hc0);
            wait_vec({vector_sw, 1'b1});
            pulse(4'b0001);
            idle(8);
        end
        // Both sources together, receiver first, then lock and unlock
        wr(8'h00, 32'h40, 4'h1);
        rx_active <= 1'b1;
        pulse(4'b1010);
        wait_vec({vector_sw, 1'b0});
        wait_vec({vector_sw, 1'b1});
        pulse(4'b0001);
        no_vec(40);
        rd_chk("rx done", 8'h00, 32'hc0);
        wait_vec({vector_sw, 1'b0});
        pulse(4'b0100);
        rd_chk("rx cleared", 8'h00, 32'h40);
        no_vec(40);
        // Modem change from clear-to-send and from ring
        wr(8'h00, 32'h20, 4'h1);
        cts <= 1'b1;
        wait_vec({vector_sw, 1'b0});
        rd_chk("modem flag", 8'h00, 32'h8020);
        wr(8'h00, 32'h8000, 4'h2);
        rd_chk("modem clear", 8'h00, 32'h20);
        ring <= 1'b1;
        idle(10);
        ring <= 1'b0;
        idle(10);
        rd_chk("short ring", 8'h00, 32'h20);
        ring <= 1'b1;
        wait_vec({vector_sw, 1'b0});
        ring <= 1'b0;
        rd_chk("long ring", 8'h00, 32'h8020);
        end_of_test();
    end
endmodule : tb
